// ===== hdl/fam_consts.svh
// fetch address match: register map, field positions, reset values
// assumes a 32-bit AHB-Lite register bus and 24-bit bank:pc fetch addresses
`ifndef FAM_CONSTS_SVH
`define FAM_CONSTS_SVH

// word indices of the registers
`define FAM_OFS_CTRL0    3'h0
`define FAM_OFS_CTRL1    3'h1
`define FAM_OFS_CMP0     3'h2
`define FAM_OFS_CMP1     3'h3
`define FAM_OFS_STAT     3'h4
`define FAM_OFS_MASK     3'h5
`define FAM_OFS_SAVED    3'h6

// field positions
`define FAM_CTRL0_EN     2
`define FAM_CTRL1_GATE   0
`define FAM_CTRL1_DEC    1
`define FAM_STAT_DET     0
`define FAM_STAT_BLK     1

// reset values
`define FAM_RST_SEL      2'h0
`define FAM_RST_CMP      24'h00_0000
`define FAM_RST_MASK     2'h0

`endif

// ===== hdl/fam_pkg.sv
// fetch address match: shared types
// assumes nothing beyond the constants header
package fam_pkg;
  typedef logic [23:0] fam_addr_t;
  typedef enum logic [1:0] {
    FAM_COND_CMP0,
    FAM_COND_CMP1,
    FAM_COND_EITHER,
    FAM_COND_OUTSIDE
  } fam_cond_t;
endpackage

// ===== hdl/fam_cmp_if.sv
// fetch address match: compare bundle between top and comparator
// assumes both ends run on the same clock
interface fam_cmp_if;
  import fam_pkg::*;
  fam_addr_t addr;
  fam_addr_t cmp0;
  fam_addr_t cmp1;
  fam_cond_t cond;
  logic      hit;
  logic      which;
  modport src (output addr, cmp0, cmp1, cond, input hit, which);
  modport cmp (input addr, cmp0, cmp1, cond, output hit, which);
endinterface

// ===== hdl/fam_match.sv
// fetch address match: pure combinational condition evaluator
// assumes the caller registers the result
module fam_match (
  fam_cmp_if.cmp c  // compare bundle
);
  import fam_pkg::*;
  logic eq0;
  logic eq1;

  // full 24-bit compares
  // all address bits
  assign eq0 = (c.addr == c.cmp0);
  assign eq1 = (c.addr == c.cmp1);

  // only the selected condition counts
  // one condition evaluated
  always_comb begin
    unique case (c.cond)
      FAM_COND_CMP0:    c.hit = eq0;
      FAM_COND_CMP1:    c.hit = eq1;
      FAM_COND_EITHER:  c.hit = eq0 | eq1;
      FAM_COND_OUTSIDE: c.hit = (c.addr < c.cmp0) | (c.addr > c.cmp1);
    endcase
  end

  // one when compare one matched; zero wins if both match
  // which register
  assign c.which = ~eq0 & eq1;
endmodule

// ===== hdl/fam_top.sv
// fetch address match: top with AHB-Lite registers and cpu fetch port
// assumes fetch and acknowledge come from cpu logic on mclk
`include "fam_consts.svh"
module fam_top (
  input  wire logic              mclk,          // 100 MHz clock
  input  wire logic              nrst,          // sync reset, low
  input  wire logic              hsel,          // slave select
  input  wire logic [31:0]       haddr,         // byte address
  input  wire logic [1:0]        htrans,        // transfer type
  input  wire logic              hwrite,        // write when high
  input  wire logic [2:0]        hsize,         // word only
  input  wire logic [31:0]       hwdata,        // write data
  input  wire logic              hready,        // bus ready
  output logic      [31:0]       hrdata,        // read data
  output logic                   hreadyout,     // slave ready
  output logic                   hresp,         // always okay
  input  wire logic              fetch_valid,   // fetch start strobe
  input  wire logic [7:0]        program_bank,  // fetch bank
  input  wire logic [15:0]       program_pc,    // fetch offset
  input  wire logic [15:0]       processor_status_word, // cpu status
  input  wire logic              nmi_ack,       // cpu accepts request
  output logic                   fetch_squash,  // drop fetched op
  output logic                   nmi_req,       // non-maskable request
  output logic                   push_valid,    // stack push strobe
  output fam_pkg::fam_addr_t     push_addr,     // saved bank and pc
  output logic      [15:0]       push_psw,      // saved status word
  output logic                   irq            // status interrupt
);
  import fam_pkg::*;

  fam_cond_t cond;
  logic      detect_en;
  logic      gate;
  logic      decision;
  fam_addr_t cmp0;
  fam_addr_t cmp1;
  fam_addr_t saved;
  logic [1:0] stat;
  logic [1:0] mask;
  logic       dp_pend;
  logic       dp_write;
  logic       dp_mapped;
  logic [2:0] dp_idx;
  logic       addr_take;
  logic       wr_now;
  logic       rd_now;
  logic       blocked;
  logic       detect;
  logic [1:0] next_stat;
  logic [1:0] next_mask;
  logic [31:0] next_rdata;
  fam_addr_t  fetch_addr;

  fam_cmp_if cmp_bus ();

  // fetch address is bank above pc
  assign fetch_addr = {program_bank, program_pc};

  // every fetch is compared against both registers
  // fetch compare
  assign cmp_bus.addr = fetch_addr;
  assign cmp_bus.cmp0 = cmp0;
  assign cmp_bus.cmp1 = cmp1;
  assign cmp_bus.cond = cond;

  fam_match u_match (
    .c (cmp_bus)
  );

  // a hit counts only while enabled and no request waits
  // enable gates requests
  assign detect = fetch_valid & detect_en & ~nmi_req & cmp_bus.hit;

  // address phase, one word per transfer
  assign addr_take = hsel & htrans[1] & hready;

  // data phase actions land in the first data cycle, the wait state
  assign wr_now = dp_pend & dp_write & dp_mapped;
  assign rd_now = dp_pend & ~dp_write & dp_mapped;

  // compare registers shut while the gate is closed
  // gate blocks access
  assign blocked = dp_pend & dp_mapped & ~gate
                 & (dp_idx == `FAM_OFS_CMP0 || dp_idx == `FAM_OFS_CMP1);

  // capture the address phase; one wait state lets read data leave a flop
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dp_pend   <= 1'b0;
      dp_write  <= 1'b0;
      dp_mapped <= 1'b0;
      dp_idx    <= 3'h0;
      hreadyout <= 1'b1;
    end else if (addr_take && !dp_pend) begin
      dp_pend   <= 1'b1;
      dp_write  <= hwrite;
      dp_mapped <= (haddr[31:5] == 27'h000_0000) && (haddr[4:2] <= `FAM_OFS_SAVED);
      dp_idx    <= haddr[4:2];
      hreadyout <= 1'b0;
    end else begin
      dp_pend   <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // errors are never signalled
  always_ff @(posedge mclk) begin
    hresp <= 1'b0;
  end

  // read mux; unmapped and blocked words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_now && !blocked) begin
      unique case (dp_idx)
        `FAM_OFS_CTRL0: next_rdata = {29'h0000_0000, detect_en, cond};
        `FAM_OFS_CTRL1: next_rdata = {30'h0000_0000, decision, gate};
        `FAM_OFS_CMP0:  next_rdata = {8'h00, cmp0};
        `FAM_OFS_CMP1:  next_rdata = {8'h00, cmp1};
        `FAM_OFS_STAT:  next_rdata = {30'h0000_0000, stat};
        `FAM_OFS_MASK:  next_rdata = {30'h0000_0000, mask};
        `FAM_OFS_SAVED: next_rdata = {8'h00, saved};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // read data held from the ready edge until the next read
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (dp_pend && !dp_write) begin
      hrdata <= next_rdata;
    end
  end

  // control registers; enable and gate clear at reset
  // reset state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cond      <= fam_cond_t'(`FAM_RST_SEL);
      detect_en <= 1'b0;
      gate      <= 1'b0;
    end else if (wr_now && dp_idx == `FAM_OFS_CTRL0) begin
      cond      <= fam_cond_t'(hwdata[1:0]);
      detect_en <= hwdata[`FAM_CTRL0_EN];
    end else if (wr_now && dp_idx == `FAM_OFS_CTRL1) begin
      gate      <= hwdata[`FAM_CTRL1_GATE];
    end
  end

  // compare registers take writes only with the gate open
  // writes blocked
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cmp0 <= `FAM_RST_CMP;
      cmp1 <= `FAM_RST_CMP;
    end else if (wr_now && !blocked) begin
      if (dp_idx == `FAM_OFS_CMP0) begin
        cmp0 <= hwdata[23:0];
      end
      if (dp_idx == `FAM_OFS_CMP1) begin
        cmp1 <= hwdata[23:0];
      end
    end
  end

  // decision flag follows only condition two; stale otherwise
  // decision capture
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      decision <= 1'b0;
    end else if (detect && cond == FAM_COND_EITHER) begin
      decision <= cmp_bus.which;
    end
  end

  // hit drops the fetched op and raises the request until accepted
  // squash and request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fetch_squash <= 1'b0;
      nmi_req      <= 1'b0;
    end else begin
      fetch_squash <= detect;
      if (detect) begin
        nmi_req <= 1'b1;
      end else if (nmi_ack) begin
        nmi_req <= 1'b0;
      end
    end
  end

  // the address that met the condition is the return address
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      saved <= `FAM_RST_CMP;
    end else if (detect) begin
      saved <= fetch_addr;
    end
  end

  // on acceptance hand bank, pc and status to the stack pusher
  // stack push
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      push_valid <= 1'b0;
      push_addr  <= `FAM_RST_CMP;
      push_psw   <= 16'h0000;
    end else begin
      push_valid <= nmi_req & nmi_ack;
      if (nmi_req && nmi_ack) begin
        push_addr <= saved;
        push_psw  <= processor_status_word;
      end
    end
  end

  // sticky status: a new event beats a same-cycle clear
  always_comb begin
    next_stat = stat;
    if (wr_now && dp_idx == `FAM_OFS_STAT) begin
      next_stat = stat & ~hwdata[1:0];
    end
    if (detect) begin
      next_stat[`FAM_STAT_DET] = 1'b1;
    end
    if (blocked) begin
      next_stat[`FAM_STAT_BLK] = 1'b1;
    end
  end

  // mask as it will stand, so irq never lags a mask write by a cycle
  assign next_mask = (wr_now && dp_idx == `FAM_OFS_MASK) ? hwdata[1:0] : mask;

  // status, mask and level interrupt
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat <= 2'h0;
      mask <= `FAM_RST_MASK;
      irq  <= 1'b0;
    end else begin
      stat <= next_stat;
      if (wr_now && dp_idx == `FAM_OFS_MASK) begin
        mask <= hwdata[1:0];
      end
      irq <= |(next_stat & next_mask);
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  squash_on_hit_a: assert property (
    detect |=> fetch_squash && nmi_req && saved == $past(fetch_addr))
    else $error("hit did not squash and request");

  req_needs_en_a: assert property (
    $rose(nmi_req) |-> $past(detect_en) && $past(fetch_valid))
    else $error("request raised while disabled");

  cond_zero_a: assert property (
    $rose(nmi_req) && $past(cond) == FAM_COND_CMP0 |-> saved == $past(cmp0))
    else $error("condition zero fired off compare zero");

  cond_one_a: assert property (
    $rose(nmi_req) && $past(cond) == FAM_COND_CMP1 |-> saved == $past(cmp1))
    else $error("condition one fired off compare one");

  cond_either_a: assert property (
    fetch_valid && detect_en && !nmi_req && cond == FAM_COND_EITHER
    && (fetch_addr == cmp0 || fetch_addr == cmp1) |=> nmi_req)
    else $error("condition two missed a match");

  cond_outside_a: assert property (
    $rose(nmi_req) && $past(cond) == FAM_COND_OUTSIDE
    |-> saved < $past(cmp0) || saved > $past(cmp1))
    else $error("out-of-range fired inside window");

  gate_read_a: assert property (
    rd_now && blocked |=> hrdata == 32'h0000_0000 && hreadyout)
    else $error("compare register read through closed gate");

  gate_write_a: assert property (
    wr_now && blocked |=> $stable(cmp0) && $stable(cmp1))
    else $error("compare register written through closed gate");

  decision_a: assert property (
    detect && cond == FAM_COND_EITHER |=> decision == (saved != cmp0))
    else $error("decision flag wrong");

  push_saved_a: assert property (
    nmi_req && nmi_ack |=> push_valid && push_addr == $past(saved) ##1 !push_valid)
    else $error("push did not carry saved address");

  reset_clear_a: assert property (
    @(posedge mclk) disable iff (1'b0) !nrst |=> !detect_en && !gate && !nmi_req)
    else $error("enable or gate set after reset");

  read_wait_a: assert property (
    addr_take && !dp_pend |=> !hreadyout ##1 hreadyout)
    else $error("data phase length wrong");

  hit_either_c:  cover property (detect && cond == FAM_COND_EITHER);
  hit_outside_c: cover property (detect && cond == FAM_COND_OUTSIDE);
  blocked_c:     cover property (blocked);
  accept_c:      cover property (nmi_req && nmi_ack);
endmodule

// ===== verif/fam_cpu_model.sv
// cpu side model: issues instruction fetches, accepts the detection request
// assumes the block answers on mclk as its port notes describe
module fam_cpu_model (
  input  wire logic               mclk,        // clock
  input  wire logic               nrst,        // sync reset, low
  input  wire logic [1:0]         ack_dly,     // wait before accepting
  input  wire logic               nmi_req,     // request from block
  input  wire logic               push_valid,  // push strobe
  input  wire fam_pkg::fam_addr_t push_addr,   // pushed bank and pc
  input  wire logic [15:0]        push_psw,    // pushed status word
  output logic                    fetch_valid, // fetch start strobe
  output logic [7:0]              program_bank,          // fetch bank
  output logic [15:0]             program_pc,            // fetch offset
  output logic [15:0]             processor_status_word, // status
  output logic                    nmi_ack,     // request accepted
  output fam_pkg::fam_addr_t      saved_addr,  // stacked address
  output logic [15:0]             saved_psw    // stacked status
);
  import fam_pkg::*;
  logic [1:0] wait_cnt;

  initial begin
    fetch_valid = 1'b0;
    {program_bank, program_pc} = 24'h00_0000;
    processor_status_word = 16'h0000;
    nmi_ack = 1'b0;
  end

  // fetch start
  // address released to its inverse so a stale value never matches
  task automatic fetch(input fam_addr_t a, input logic [15:0] s);
    @(posedge mclk);
    fetch_valid <= 1'b1;
    {program_bank, program_pc} <= a;
    processor_status_word <= s;
    @(posedge mclk);
    fetch_valid <= 1'b0;
    {program_bank, program_pc} <= ~a;
  endtask

  // accept request
  // slow or prompt acceptance, one-cycle acknowledge
  always @(posedge mclk) begin
    if (!nrst || !nmi_req || nmi_ack) begin
      nmi_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      nmi_ack <= (wait_cnt == ack_dly);
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  always @(posedge mclk) begin
    if (push_valid) begin
      saved_addr <= push_addr;
      saved_psw <= push_psw;
    end
  end
endmodule

// ===== verif/fetch_address_match_debug_tb.sv
// bench for the fetch address match block: bus, fetch and request checks
// assumes the cpu model file and the design files are compiled first
`include "fam_consts.svh"
module fetch_address_match_debug_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fam_pkg::*;
  localparam logic [4:0] A_C0 = {`FAM_OFS_CTRL0, 2'b00};
  localparam logic [4:0] A_C1 = {`FAM_OFS_CTRL1, 2'b00};
  localparam logic [4:0] A_K0 = {`FAM_OFS_CMP0, 2'b00};
  localparam logic [4:0] A_K1 = {`FAM_OFS_CMP1, 2'b00};
  localparam logic [4:0] A_ST = {`FAM_OFS_STAT, 2'b00};
  localparam logic [4:0] A_MK = {`FAM_OFS_MASK, 2'b00};
  localparam logic [4:0] A_SV = {`FAM_OFS_SAVED, 2'b00};
  logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, fetch_valid;
  logic        nmi_ack, fetch_squash, nmi_req, push_valid, irq, en, e;
  logic [31:0] haddr, hwdata, hrdata, r, m;
  logic [1:0]  htrans, ack_dly, c;
  logic [7:0]  program_bank;
  logic [15:0] program_pc, processor_status_word, push_psw, saved_psw;
  fam_addr_t   push_addr, saved_addr, a, k0, k1;
  int          n_mismatch, total_checks;
  integer      seed;

  fam_top uut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fetch_valid(fetch_valid), .program_bank(program_bank),
    .program_pc(program_pc), .processor_status_word(processor_status_word),
    .nmi_ack(nmi_ack), .fetch_squash(fetch_squash), .nmi_req(nmi_req),
    .push_valid(push_valid), .push_addr(push_addr), .push_psw(push_psw),
    .irq(irq));

  fam_cpu_model cpu (.mclk(mclk), .nrst(nrst), .ack_dly(ack_dly),
    .nmi_req(nmi_req), .push_valid(push_valid), .push_addr(push_addr),
    .push_psw(push_psw), .fetch_valid(fetch_valid),
    .program_bank(program_bank), .program_pc(program_pc),
    .processor_status_word(processor_status_word), .nmi_ack(nmi_ack),
    .saved_addr(saved_addr), .saved_psw(saved_psw));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chkb(input string nm, input logic x, input logic g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, x, g);
    end
  endtask

  // single word transfer; r takes read data at the closing edge
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, ad};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic setk(input logic [4:0] ad, input fam_addr_t v);
    bus(1'b1, A_C1, 32'h1);
    bus(1'b1, ad, {8'h00, v});
    bus(1'b1, A_C1, 32'h0);
  endtask

  function automatic logic hit_of(input logic [1:0] cc, input fam_addr_t x, y0, y1);
    case (cc)
      2'h0: return x == y0;
      2'h1: return x == y1;
      2'h2: return x == y0 || x == y1;
      default: return x < y0 || x > y1;
    endcase
  endfunction

  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    summarize;
  end

  initial begin
    seed = 32'h4807;
    {nrst, hsel, hwrite, htrans, ack_dly} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    bus(1'b0, A_C0, 32'h0); chk("ctrl0", 32'h0, r);
    bus(1'b0, A_C1, 32'h0); chk("ctrl1", 32'h0, r);
    bus(1'b0, A_MK, 32'h0); chk("mask", 32'h0, r);
    chkb("hresp", 1'b0, hresp);
    $display("test reset done");
    setk(A_K0, 24'h65_4321);
    bus(1'b1, A_K0, 32'h0012_3456);
    bus(1'b0, A_K0, 32'h0); chk("gated read", 32'h0, r);
    bus(1'b0, A_ST, 32'h0); chk("blocked flag", 32'h2, r);
    bus(1'b1, A_ST, 32'h3);
    bus(1'b1, A_C1, 32'h1);
    bus(1'b0, A_K0, 32'h0); chk("cmp0 kept", 32'h0065_4321, r);
    bus(1'b1, A_C1, 32'h0);
    bus(1'b0, 5'h1C, 32'h0); chk("unmapped", 32'h0, r);
    $display("test gate done");
    for (int i = 0; i < 60; i++) begin
      m = $random(seed);
      c = (i < 4) ? 2'(i) : 2'($random(seed));
      k0 = 24'($random(seed));
      k1 = 24'($random(seed));
      en = (i % 4 != 3);
      case (m[2:0])
        3'h0: a = k0;
        3'h1: a = k1;
        3'h2: a = k0 - 24'h1;
        3'h3: a = k1 + 24'h1;
        3'h4: a = k0 ^ 24'h80_0000;
        3'h5: begin k1 = k0; a = k0; end
        default: a = 24'($random(seed));
      endcase
      ack_dly <= m[4:3];
      setk(A_K0, k0);
      setk(A_K1, k1);
      bus(1'b1, A_MK, {31'h0, m[5]});
      bus(1'b1, A_C0, {29'h0, en, c});
      e = en && hit_of(c, a, k0, k1);
      cpu.fetch(a, m[31:16]);
      @(posedge mclk);
      chkb("squash", e, fetch_squash);
      chkb("request", e, nmi_req);
      repeat (8) @(posedge mclk);
      chkb("irq", e & m[5], irq);
      bus(1'b0, A_ST, 32'h0); chk("status", {31'h0, e}, r);
      if (e) begin
        chk("pushed addr", {8'h00, a}, {8'h00, saved_addr});
        chk("pushed psw", {16'h0, m[31:16]}, {16'h0, saved_psw});
        bus(1'b0, A_SV, 32'h0); chk("saved addr", {8'h00, a}, r);
        if (c == 2'h2) begin
          bus(1'b0, A_C1, 32'h0); chkb("decision", a != k0, r[1]);
        end
      end
      bus(1'b1, A_ST, 32'h3);
      bus(1'b0, A_ST, 32'h0); chk("status clear", 32'h0, r);
    end
    $display("test random done");
    // mid-run reset with enable and gate both set
    bus(1'b1, A_C0, 32'h7);
    bus(1'b1, A_C1, 32'h1);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    bus(1'b0, A_C0, 32'h0); chk("ctrl0 after reset", 32'h0, r);
    bus(1'b0, A_C1, 32'h0); chk("ctrl1 after reset", 32'h0, r);
    $display("test midreset done");
    summarize;
  end
endmodule
